/* File: shared/dpdc_pkg.sv */
// Package with register map, field positions, reset values and state types of the dual timer.
`default_nettype none
package dpdc_pkg;
  localparam logic [7:0] TIMER1_PRESCALER_VALUE_OFS = 8'hd2;
  localparam logic [7:0] TIMER1_COUNT_VALUE_OFS     = 8'hd3;
  localparam logic [7:0] TIMER1_CONTROL_STATUS_OFS  = 8'hd4;
  localparam logic [7:0] TIMER2_PRESCALER_VALUE_OFS = 8'hd5;
  localparam logic [7:0] TIMER2_COUNT_VALUE_OFS     = 8'hd6;
  localparam logic [7:0] TIMER2_CONTROL_STATUS_OFS  = 8'hd7;
  localparam logic [7:0] IRQ_STATUS_OFS             = 8'hd8;
  localparam logic [7:0] IRQ_MASK_OFS               = 8'hd9;
  localparam int         ZERO_FLAG_BIT  = 7;
  localparam int         IRQ_EN_BIT     = 6;
  localparam int         PIN_DIR_BIT    = 5;
  localparam int         PIN_DATA_BIT   = 4;
  localparam int         PSC_RUN_BIT    = 3;
  localparam logic [7:0] COUNT_RESET    = 8'hff;
  localparam logic [6:0] PSC_RESET      = 7'h7f;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h3;
  localparam int         CLK_HZ         = 50000000;
  localparam int         INT_DIV        = 12;
  localparam logic [3:0] INT_DIV_LAST   = 4'(INT_DIV - 1);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] count;
    logic [6:0] timer1_prescaler_value;
    logic       tap_prev;
  } dpdc_timer_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dpdc_bus_type;
endpackage : dpdc_pkg
`default_nettype wire

/* File: rtl/dpdc_timers.sv */
// Two prescaled 8-bit down counters with a register port, interrupt status and one timer pin.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dpdc_timers (
  input  wire logic       clk,          // 50 MHz clock
  input  wire logic       resetn,       // Synchronous reset, active low
  input  wire logic [7:0] addr,         // Register address
  input  wire logic [7:0] wdata,        // Write data
  input  wire logic       wr,           // Write strobe
  input  wire logic       rd,           // Read strobe
  output var  logic [7:0] rdata,        // Read data, cycle after rd
  output var  logic [1:0] timer_irq,    // Per-timer interrupt requests
  output var  logic       irq,          // Combined masked interrupt level
  input  wire logic       timer_pin_i,  // Timer 1 pin input
  output var  logic       timer_pin_o,  // Timer 1 pin output value
  output var  logic       timer_pin_oe_n // Low while timer 1 drives the pin
);

  typedef struct packed {
    dpdc_pkg::dpdc_timer_type [1:0] tmr;
    logic [3:0] div_cnt;
    logic       div_tick;
    logic [1:0] pin_sync;
    logic       pin_prev;
    logic       pin_out;
    logic [1:0] ev_sts;
    logic [1:0] ev_mask;
    logic [7:0] rdata;
    logic [1:0] tirq;
    logic       irq;
    logic       pin_oe_n;
  } dpdc_state_type;

  dpdc_state_type s_q;
  dpdc_state_type s_d;
  dpdc_pkg::dpdc_bus_type bus;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Register offsets per timer.
  function automatic logic [7:0] ofs_psc(input int i);
    ofs_psc = (i == 0) ? dpdc_pkg::TIMER1_PRESCALER_VALUE_OFS : dpdc_pkg::TIMER2_PRESCALER_VALUE_OFS;
  endfunction : ofs_psc
  function automatic logic [7:0] ofs_cnt(input int i);
    ofs_cnt = (i == 0) ? dpdc_pkg::TIMER1_COUNT_VALUE_OFS : dpdc_pkg::TIMER2_COUNT_VALUE_OFS;
  endfunction : ofs_cnt
  function automatic logic [7:0] ofs_ctl(input int i);
    ofs_ctl = (i == 0) ? dpdc_pkg::TIMER1_CONTROL_STATUS_OFS : dpdc_pkg::TIMER2_CONTROL_STATUS_OFS;
  endfunction : ofs_ctl

  logic       pin_now;
  logic [1:0] zero_rise;

  always_comb
  begin
    logic       ps_clk;
    logic [7:0] taps;
    logic       tap;
    logic       dec;
    logic       cnt_wr;
    logic       ctl_wr;
    logic [7:0] rd_v;
    s_d       = s_q;
    ps_clk    = 1'b0;
    taps      = 8'h00;
    tap       = 1'b0;
    dec       = 1'b0;
    cnt_wr    = 1'b0;
    ctl_wr    = 1'b0;
    rd_v      = 8'h00;
    zero_rise = 2'b00;
    pin_now   = s_q.pin_sync[1];
    // Pin passes two flops; only the second stage feeds logic.
    s_d.pin_sync = {s_q.pin_sync[0], timer_pin_i};
    s_d.pin_prev = pin_now;
    // Divide-by-twelve internal tick shared by both prescalers.
    s_d.div_tick = (s_q.div_cnt == dpdc_pkg::INT_DIV_LAST);
    s_d.div_cnt  = s_d.div_tick ? 4'h0 : s_q.div_cnt + 4'h1;
    for (int i = 0; i < 2; i++)
    begin
      // Cleared per timer so that a decrement of timer 1 never leaks into timer 2.
      dec = 1'b0;
      // Timer 1 input mode picks pin source; output mode and timer 2 use internal tick.
      if (i == 0 && !s_q.tmr[0].ctrl[dpdc_pkg::PIN_DIR_BIT])
      begin
        if (s_q.tmr[0].ctrl[dpdc_pkg::PIN_DATA_BIT])
          ps_clk = s_q.div_tick && pin_now;
        else
          ps_clk = pin_now && !s_q.pin_prev;
      end
      else
        ps_clk = s_q.div_tick;
      // Tap 0 is the prescaler input; tap k is prescaler bit k-1.
      taps = {s_q.tmr[i].timer1_prescaler_value, ps_clk};
      tap  = taps[s_q.tmr[i].ctrl[2:0]];
      s_d.tmr[i].tap_prev = tap;
      if (!s_q.tmr[i].ctrl[dpdc_pkg::PSC_RUN_BIT])
      begin
        s_d.tmr[i].timer1_prescaler_value      = dpdc_pkg::PSC_RESET;
        // A held prescaler shows all ones, so a low history bit would fake a tap edge at start.
        s_d.tmr[i].tap_prev = 1'b1;
      end
      else
      begin
        if (ps_clk)
          s_d.tmr[i].timer1_prescaler_value = s_q.tmr[i].timer1_prescaler_value - 7'h01;
        // Code 000 decrements on each input pulse; higher taps on a rising bit.
        dec = (s_q.tmr[i].ctrl[2:0] == 3'h0) ? ps_clk : (tap && !s_q.tmr[i].tap_prev);
      end
      cnt_wr = bus.wr && bus.addr == ofs_cnt(i);
      ctl_wr = bus.wr && bus.addr == ofs_ctl(i);
      if (bus.wr && bus.addr == ofs_psc(i) && s_q.tmr[i].ctrl[dpdc_pkg::PSC_RUN_BIT])
        s_d.tmr[i].timer1_prescaler_value = bus.wdata[6:0];
      if (ctl_wr)
        s_d.tmr[i].ctrl = (i == 1) ? {bus.wdata[7:5], 1'b0, bus.wdata[3:0]} : bus.wdata;
      if (cnt_wr)
        s_d.tmr[i].count = bus.wdata;
      else if (dec)
      begin
        s_d.tmr[i].count = s_q.tmr[i].count - 8'h01;
        if (s_q.tmr[i].count == 8'h01)
        begin
          s_d.tmr[i].ctrl[dpdc_pkg::ZERO_FLAG_BIT] = 1'b1;
          zero_rise[i] = !s_q.tmr[i].ctrl[dpdc_pkg::ZERO_FLAG_BIT];
        end
      end
      if (zero_rise[i])
        s_d.ev_sts[i] = 1'b1;
      s_d.tirq[i] = s_d.tmr[i].ctrl[dpdc_pkg::ZERO_FLAG_BIT] && s_d.tmr[i].ctrl[dpdc_pkg::IRQ_EN_BIT];
    end
    // Pin latches the data bit on the zero flag's rising edge.
    if (zero_rise[0] && s_q.tmr[0].ctrl[dpdc_pkg::PIN_DIR_BIT])
      s_d.pin_out = s_q.tmr[0].ctrl[dpdc_pkg::PIN_DATA_BIT];
    // Status: write one clears, but a new event wins.
    if (bus.wr && bus.addr == dpdc_pkg::IRQ_STATUS_OFS)
      s_d.ev_sts = (s_q.ev_sts & ~bus.wdata[1:0]) | zero_rise;
    if (bus.wr && bus.addr == dpdc_pkg::IRQ_MASK_OFS)
      s_d.ev_mask = bus.wdata[1:0];
    s_d.irq = |(s_d.ev_sts & s_d.ev_mask);
    s_d.pin_oe_n = !s_d.tmr[0].ctrl[dpdc_pkg::PIN_DIR_BIT];
    unique case (bus.addr)
      dpdc_pkg::TIMER1_PRESCALER_VALUE_OFS: rd_v = {1'b0, s_q.tmr[0].timer1_prescaler_value};
      dpdc_pkg::TIMER1_COUNT_VALUE_OFS:     rd_v = s_q.tmr[0].count;
      dpdc_pkg::TIMER1_CONTROL_STATUS_OFS:  rd_v = s_q.tmr[0].ctrl;
      dpdc_pkg::TIMER2_PRESCALER_VALUE_OFS: rd_v = {1'b0, s_q.tmr[1].timer1_prescaler_value};
      dpdc_pkg::TIMER2_COUNT_VALUE_OFS:     rd_v = s_q.tmr[1].count;
      dpdc_pkg::TIMER2_CONTROL_STATUS_OFS:  rd_v = s_q.tmr[1].ctrl;
      dpdc_pkg::IRQ_STATUS_OFS:             rd_v = {6'h00, s_q.ev_sts};
      dpdc_pkg::IRQ_MASK_OFS:               rd_v = {6'h00, s_q.ev_mask};
      default:                              rd_v = 8'h00;
    endcase
    s_d.rdata = bus.rd ? rd_v : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 2; i++)
      begin
        s_q.tmr[i].ctrl     <= dpdc_pkg::CTRL_RESET;
        s_q.tmr[i].count    <= dpdc_pkg::COUNT_RESET;
        s_q.tmr[i].timer1_prescaler_value      <= dpdc_pkg::PSC_RESET;
        s_q.tmr[i].tap_prev <= 1'b1;
      end
      s_q.div_cnt  <= 4'h0;
      s_q.div_tick <= 1'b0;
      s_q.pin_sync <= 2'b00;
      s_q.pin_prev <= 1'b0;
      s_q.pin_out  <= 1'b0;
      s_q.ev_sts   <= 2'b00;
      s_q.ev_mask  <= dpdc_pkg::IRQ_MASK_RESET;
      s_q.rdata    <= 8'h00;
      s_q.tirq     <= 2'b00;
      s_q.irq      <= 1'b0;
      s_q.pin_oe_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign rdata          = s_q.rdata;
  assign timer_irq      = s_q.tirq;
  assign irq            = s_q.irq;
  assign timer_pin_o    = s_q.pin_out;
  assign timer_pin_oe_n = s_q.pin_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_zero_flag;
    @(posedge clk) disable iff (!resetn)
    (s_q.tmr[0].ctrl[dpdc_pkg::PSC_RUN_BIT] && s_q.tmr[0].ctrl[2:0] == 3'h0 && s_q.div_tick
     && s_q.tmr[0].ctrl[dpdc_pkg::PIN_DIR_BIT] && s_q.tmr[0].count == 8'h01
     && !(wr && addr == dpdc_pkg::TIMER1_COUNT_VALUE_OFS)
     && !(wr && addr == dpdc_pkg::TIMER1_CONTROL_STATUS_OFS))
    |=> s_q.tmr[0].ctrl[dpdc_pkg::ZERO_FLAG_BIT] && s_q.tmr[0].count == 8'h00;
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag not set");

  property p_irq;
    @(posedge clk) disable iff (!resetn)
    timer_irq[0] == (s_q.tmr[0].ctrl[dpdc_pkg::ZERO_FLAG_BIT] && s_q.tmr[0].ctrl[dpdc_pkg::IRQ_EN_BIT])
    && timer_irq[1] == (s_q.tmr[1].ctrl[dpdc_pkg::ZERO_FLAG_BIT] && s_q.tmr[1].ctrl[dpdc_pkg::IRQ_EN_BIT]);
  endproperty
  a_irq: assert property (p_irq) else $error("timer irq mismatch");

  property p_dir;
    @(posedge clk) disable iff (!resetn)
    timer_pin_oe_n == !s_q.tmr[0].ctrl[dpdc_pkg::PIN_DIR_BIT];
  endproperty
  a_dir: assert property (p_dir) else $error("pin direction wrong");

  property p_pin_out;
    @(posedge clk) disable iff (!resetn)
    (s_q.tmr[0].ctrl[dpdc_pkg::PIN_DIR_BIT] && $rose(s_q.tmr[0].ctrl[dpdc_pkg::ZERO_FLAG_BIT])
     && !$past(wr && addr == dpdc_pkg::TIMER1_CONTROL_STATUS_OFS))
    |-> timer_pin_o == $past(s_q.tmr[0].ctrl[dpdc_pkg::PIN_DATA_BIT]);
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin data not latched");

  // The pin output may only move on the edge at which the zero flag rises.
  property p_pin_steady;
    @(posedge clk) disable iff (!resetn)
    !$rose(s_q.tmr[0].ctrl[dpdc_pkg::ZERO_FLAG_BIT]) |-> $stable(timer_pin_o);
  endproperty
  a_pin_steady: assert property (p_pin_steady) else $error("pin moved without zero flag");

  property p_hold;
    @(posedge clk) disable iff (!resetn)
    (!s_q.tmr[1].ctrl[dpdc_pkg::PSC_RUN_BIT] && !(wr && addr == dpdc_pkg::TIMER2_COUNT_VALUE_OFS))
    |=> s_q.tmr[1].timer1_prescaler_value == dpdc_pkg::PSC_RESET && $stable(s_q.tmr[1].count);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped timer moved");

  property p_psc_read;
    @(posedge clk) disable iff (!resetn)
    (rd && addr == dpdc_pkg::TIMER2_PRESCALER_VALUE_OFS) |=> rdata == {1'b0, $past(s_q.tmr[1].timer1_prescaler_value)};
  endproperty
  a_psc_read: assert property (p_psc_read) else $error("prescaler read wrong");

  property p_write_wins;
    @(posedge clk) disable iff (!resetn)
    (wr && addr == dpdc_pkg::TIMER1_COUNT_VALUE_OFS && !s_q.tmr[0].ctrl[dpdc_pkg::ZERO_FLAG_BIT] && !(rd && wr))
    |=> !s_q.tmr[0].ctrl[dpdc_pkg::ZERO_FLAG_BIT] && s_q.tmr[0].count == $past(wdata);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("count write lost");

  // Twelve cycles from one internal tick to the next, with none in between.
  sequence s_div_tick;
    s_q.div_tick ##1 !s_q.div_tick [*8] ##1 !s_q.div_tick [*3];
  endsequence
  property p_div12;
    @(posedge clk) disable iff (!resetn)
    s_q.div_tick |-> s_div_tick ##1 s_q.div_tick;
  endproperty
  a_div12: assert property (p_div12) else $error("divide by twelve broken");

  sequence s_t2_tick;
    s_q.tmr[1].ctrl[dpdc_pkg::PSC_RUN_BIT] && s_q.tmr[1].ctrl[2:0] == 3'h0 && s_q.div_tick;
  endsequence
  property p_t2_step;
    @(posedge clk) disable iff (!resetn)
    s_t2_tick ##0 !(wr && addr == dpdc_pkg::TIMER2_COUNT_VALUE_OFS)
    |=> s_q.tmr[1].count == $past(s_q.tmr[1].count) - 8'h01;
  endproperty
  a_t2_step: assert property (p_t2_step) else $error("timer 2 missed a step");

  // Only tap code 000 is watched: a higher tap can still show an edge launched before the gate closed.
  sequence s_gate_closed;
    !s_q.tmr[0].ctrl[dpdc_pkg::PIN_DIR_BIT] && s_q.tmr[0].ctrl[dpdc_pkg::PIN_DATA_BIT]
    && s_q.tmr[0].ctrl[2:0] == 3'h0 && !s_q.pin_sync[1];
  endsequence
  property p_gate_closed;
    @(posedge clk) disable iff (!resetn)
    s_gate_closed ##0 !(wr && addr == dpdc_pkg::TIMER1_COUNT_VALUE_OFS) |=> $stable(s_q.tmr[0].count);
  endproperty
  a_gate_closed: assert property (p_gate_closed) else $error("gated count moved with pin low");

  property p_reset_vals;
    @(posedge clk)
    !resetn |=> rdata == 8'h00 && timer_irq == 2'b00 && !irq && timer_pin_oe_n
      && s_q.tmr[0].count == dpdc_pkg::COUNT_RESET && s_q.tmr[1].timer1_prescaler_value == dpdc_pkg::PSC_RESET
      && s_q.tmr[1].ctrl == dpdc_pkg::CTRL_RESET;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

endmodule : dpdc_timers
`default_nettype wire

/* File: testbench/dpdc_pin_model.sv */
// Far-side model of the timer 1 pin: sends rising edges or a high level.
`timescale 1ns/1ps
`default_nettype none
module dpdc_pin_model (
  input  wire logic       clk,       // Bench clock
  input  wire logic [7:0] n_pulses,  // Edges per burst
  input  wire logic       go,        // Starts a burst
  input  wire logic       hold_high, // Level for gated counting
  input  wire logic       pin_o,     // Timer output value
  input  wire logic       pin_oe_n,  // Low while the timer drives
  output var  logic       pin        // Resolved line level
);
  logic drv_q = 1'b0;
  // Edges are eight cycles apart so the input synchroniser catches each one.
  always @(posedge go)
  begin
    repeat (n_pulses)
    begin
      repeat (4) @(posedge clk);
      drv_q <= 1'b1;
      repeat (4) @(posedge clk);
      drv_q <= 1'b0;
    end
  end
  assign pin = !pin_oe_n ? pin_o : (drv_q | hold_high);
endmodule : dpdc_pin_model
`default_nettype wire

/* File: testbench/tb_dpdc_timers.sv */
// Self-checking bench for the dual prescaled down counter block.
`timescale 1ns/1ps
`default_nettype none
module tb_dpdc_timers;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic [1:0] timer_irq;
  logic       irq;
  logic       pin;
  logic       pin_o;
  logic       pin_oe_n;
  logic [7:0] n_pulses = 8'h00;
  logic       go = 1'b0;
  logic       hold_high = 1'b0;
  int         n_fail = 0;
  int         num_checks = 0;
  int         t;
  logic [7:0] v;
  localparam logic [7:0] RA [9] = '{8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd7, 8'hd8, 8'hd9, 8'he0};
  localparam logic [7:0] RV [9] = '{8'h7f, 8'hff, 8'h00, 8'h7f, 8'hff, 8'h00, 8'h00, 8'h03, 8'h00};
  always #10 clk = ~clk;
  dpdc_timers DUT (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .timer_irq(timer_irq), .irq(irq), .timer_pin_i(pin), .timer_pin_o(pin_o),
    .timer_pin_oe_n(pin_oe_n));
  dpdc_pin_model PM (.clk(clk), .n_pulses(n_pulses), .go(go), .hold_high(hold_high), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .pin(pin));
  ////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a);
    chk(v, e);
  endtask : rdchk
  // A stopped timer is rearmed so the flag really rises again.
  task automatic arm1(input logic [7:0] cnt, input logic [7:0] ctrl);
    wr_reg(8'hd4, 8'h00);
    wr_reg(8'hd3, cnt);
    wr_reg(8'hd4, ctrl);
  endtask : arm1
  task automatic wait_irq(input int i, input int max);
    t = 0;
    while (timer_irq[i] !== 1'b1)
    begin
      cyc(1);
      t++;
      if (t > max)
      begin
        n_fail++;
        $display("ERROR t=%0t got %h exp %h", $time, t, max);
        final_report();
      end
    end
  endtask : wait_irq
  ////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    foreach (RA[i]) rdchk(RA[i], RV[i]);
    wr_reg(8'hd3, 8'ha5);
    rdchk(8'hd3, 8'ha5);
    wr_reg(8'hd2, 8'h12);
    rdchk(8'hd2, 8'h7f);
    wr_reg(8'hd7, 8'h3f);
    rdchk(8'hd7, 8'h2f);
    wr_reg(8'hd7, 8'h20);
    wr_reg(8'he0, 8'h55);
    rdchk(8'he0, 8'h00);
    wr_reg(8'hd4, 8'h08);
    wr_reg(8'hd2, 8'h40);
    rdchk(8'hd2, 8'h40);
    wr_reg(8'hd4, 8'h28);
    cyc(48);
    rd_reg(8'hd2);
    chk({7'h0, v < 8'h40 && v >= 8'h3a}, 8'h01);
    wr_reg(8'hd4, 8'h00);
    rdchk(8'hd2, 8'h7f);
    $display("test registers done");
    for (int k = 0; k < 8; k++)
    begin
      arm1(8'h03, 8'h68 | 8'(k));
      wait_irq(0, 5000);
      chk({7'h0, t > 24 << k && t <= (36 << k) + 16}, 8'h01);
    end
    rdchk(8'hd4, 8'hef);
    rdchk(8'hd3, 8'h00);
    $display("test taps done");
    cyc(2);
    chk({7'h0, irq}, 8'h01);
    wr_reg(8'hd9, 8'h00);
    cyc(2);
    chk({7'h0, irq}, 8'h00);
    wr_reg(8'hd9, 8'h03);
    cyc(2);
    chk({7'h0, irq}, 8'h01);
    wr_reg(8'hd8, 8'h01);
    cyc(2);
    chk({7'h0, irq}, 8'h00);
    wr_reg(8'hd4, 8'h80);
    cyc(2);
    chk({6'h0, timer_irq}, 8'h00);
    wr_reg(8'hd4, 8'h00);
    wr_reg(8'hd6, 8'h02);
    wr_reg(8'hd7, 8'h68);
    wait_irq(1, 60);
    chk({7'h0, timer_irq[0]}, 8'h00);
    rdchk(8'hd7, 8'he8);
    wr_reg(8'hd7, 8'h20);
    chk({7'h0, irq}, 8'h01);
    rdchk(8'hd8, 8'h02);
    wr_reg(8'hd8, 8'h02);
    rdchk(8'hd8, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("test interrupts done");
    arm1(8'h01, 8'h78);
    cyc(2);
    chk({7'h0, pin_oe_n}, 8'h00);
    wait_irq(0, 40);
    cyc(2);
    chk({7'h0, pin_o}, 8'h01);
    arm1(8'h01, 8'h68);
    wait_irq(0, 40);
    cyc(2);
    chk({7'h0, pin_o}, 8'h00);
    wr_reg(8'hd4, 8'h00);
    cyc(2);
    chk({7'h0, pin_oe_n}, 8'h01);
    arm1(8'h05, 8'h48);
    cyc(60);
    rdchk(8'hd3, 8'h05);
    @(posedge clk);
    n_pulses <= 8'h05;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_irq(0, 80);
    arm1(8'h03, 8'h58);
    cyc(60);
    rdchk(8'hd3, 8'h03);
    @(posedge clk);
    hold_high <= 1'b1;
    wait_irq(0, 80);
    $display("test pin modes done");
    final_report();
  end
endmodule : tb_dpdc_timers
`default_nettype wire
